// File: cact_pkg.sv
// package for the counter array capture timer block
package cact_pkg;
  localparam logic [7:0] CACT_CLK_CTRL_ADDR = 8'h00_FC;
  localparam logic [7:0] CACT_CLK_CTRL_RESET = 8'h00_10;
  localparam int CACT_GATE_BIT = 4;
  localparam int CACT_EXP_MSB = 3;
  localparam int CACT_EXP_WIDTH = 4;
  localparam int CACT_CNT_WIDTH = 16;
  localparam logic [15:0] CACT_CNT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CACT_MODE_OFF = 2'b00,
    CACT_MODE_CAPTURE = 2'b01,
    CACT_MODE_TIMER = 2'b10,
    CACT_MODE_PWM = 2'b11
  } cact_mode_e;

  typedef enum logic [1:0] {
    CACT_EDGE_NONE = 2'b00,
    CACT_EDGE_RISE = 2'b01,
    CACT_EDGE_FALL = 2'b10,
    CACT_EDGE_ANY = 2'b11
  } cact_edge_e;

  typedef struct packed {
    logic [2:0] rsvd;
    logic gate;
    logic [3:0] exponent;
  } cact_clk_ctrl_s;

  // per-unit configuration from the cpu side
  typedef struct packed {
    cact_mode_e mode;
    cact_edge_e edge_sel;
    logic irq_en;
    logic [15:0] compare;
  } cact_unit_cfg_s;
endpackage : cact_pkg

// File: cact_top.sv
// counter array: prescaler, 16-bit counter and capture/compare units
`timescale 1ns/10ps
module cact_top
  import cact_pkg::*;
#(
  parameter int UNITS = 3
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  output logic [7:0] sfr_rdata_out,
  input wire cact_unit_cfg_s [UNITS-1:0] unit_cfg_in,
  input wire logic [UNITS-1:0] unit_pin_in,
  input wire logic [UNITS-1:0] unit_irq_clear_in,
  output logic [UNITS-1:0][15:0] capture_compare_value_out,
  output logic [UNITS-1:0] unit_irq_out,
  output logic [15:0] counter_out,
  output logic array_tick_clock_out
);
  // the largest exponent needs one divider bit per halving, so 15 bits for a divide by 32768
  localparam int DIV_WIDTH = (1 << CACT_EXP_WIDTH) - 1;

  cact_clk_ctrl_s array_clock_control_reg;
  cact_clk_ctrl_s array_clock_control_next;
  logic [DIV_WIDTH-1:0] div_reg;
  logic [DIV_WIDTH-1:0] div_mask;
  logic tick;
  logic tick_seen_reg;
  logic [CACT_CNT_WIDTH-1:0] cnt_reg;

  always_comb begin
    array_clock_control_next = array_clock_control_reg;
    if (sfr_wr_in && sfr_addr_in == CACT_CLK_CTRL_ADDR) begin
      array_clock_control_next = cact_clk_ctrl_s'(sfr_wdata_in);
      // reserved bits are not stored, so they always read back as zero
      array_clock_control_next.rsvd = '0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      array_clock_control_reg <= cact_clk_ctrl_s'(CACT_CLK_CTRL_RESET);
    end else begin
      array_clock_control_reg <= array_clock_control_next;
    end
  end

  always_comb begin
    sfr_rdata_out = 8'h00;
    if (sfr_addr_in == CACT_CLK_CTRL_ADDR) begin
      sfr_rdata_out = array_clock_control_reg;
    end
  end

  // mask of low bits that must be all ones for a tick: 2^exp - 1
  assign div_mask = ~({DIV_WIDTH{1'b1}} << array_clock_control_reg.exponent);
  assign tick = array_clock_control_reg.gate && ((div_reg & div_mask) == div_mask);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= '0;
    end else if (array_clock_control_reg.gate) begin
      div_reg <= div_reg + DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= CACT_CNT_RESET;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  assign counter_out = cnt_reg;
  assign array_tick_clock_out = tick;

  // pins are asynchronous: two flops before any logic, third for edge history
  logic [UNITS-1:0] pin_s1_reg;
  logic [UNITS-1:0] pin_s2_reg;
  logic [UNITS-1:0] pin_s3_reg;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= unit_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  logic [UNITS-1:0] cap_event;
  logic [UNITS-1:0] match_event;

  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_unit
      logic rise;
      logic fall;
      logic [15:0] val_reg;
      logic irq_reg;
      assign rise = pin_s2_reg[g] && !pin_s3_reg[g];
      assign fall = !pin_s2_reg[g] && pin_s3_reg[g];
      // each unit decodes its own mode field
      assign cap_event[g] = (unit_cfg_in[g].mode == CACT_MODE_CAPTURE) &&
        ((unit_cfg_in[g].edge_sel[0] && rise) || (unit_cfg_in[g].edge_sel[1] && fall));
      // compare only when the counter has just moved, so one match per value
      assign match_event[g] = (unit_cfg_in[g].mode == CACT_MODE_TIMER) &&
        (cnt_reg == unit_cfg_in[g].compare) && tick_seen_reg;

      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          val_reg <= CACT_CNT_RESET;
        end else if (cap_event[g]) begin
          val_reg <= cnt_reg;
        end else if (unit_cfg_in[g].mode == CACT_MODE_TIMER) begin
          val_reg <= unit_cfg_in[g].compare;
        end
      end

      // set wins over clear
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          irq_reg <= 1'b0;
        end else if (unit_cfg_in[g].irq_en && (cap_event[g] || match_event[g])) begin
          irq_reg <= 1'b1;
        end else if (unit_irq_clear_in[g]) begin
          irq_reg <= 1'b0;
        end
      end

      assign capture_compare_value_out[g] = val_reg;
      assign unit_irq_out[g] = irq_reg;

      a_capture_loads: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cap_event[g] |=> val_reg == $past(cnt_reg))
        else $error("capture value wrong");
      a_irq_on_event: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (unit_cfg_in[g].irq_en && (cap_event[g] || match_event[g])) |=> irq_reg)
        else $error("unit interrupt not raised");

      // steps of a capture or a match: the pin edge leaves the synchroniser or the count meets compare, the result lands one edge later
      sequence s_pin_rose;
        pin_s2_reg[g] && !pin_s3_reg[g];
      endsequence
      sequence s_pin_fell;
        !pin_s2_reg[g] && pin_s3_reg[g];
      endsequence
      sequence s_count_hits_compare;
        (unit_cfg_in[g].mode == CACT_MODE_TIMER) && tick_seen_reg &&
          (cnt_reg == unit_cfg_in[g].compare);
      endsequence

      a_rise_capture: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (unit_cfg_in[g].mode == CACT_MODE_CAPTURE && unit_cfg_in[g].edge_sel[0])
        ##0 s_pin_rose |=> val_reg == $past(cnt_reg))
        else $error("rising edge not captured");
      a_fall_capture: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (unit_cfg_in[g].mode == CACT_MODE_CAPTURE && unit_cfg_in[g].edge_sel[1])
        ##0 s_pin_fell |=> val_reg == $past(cnt_reg))
        else $error("falling edge not captured");
      a_wrong_edge: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (unit_cfg_in[g].mode == CACT_MODE_CAPTURE && unit_cfg_in[g].edge_sel == CACT_EDGE_RISE)
        ##0 s_pin_fell |=> val_reg == $past(val_reg))
        else $error("capture on unselected edge");
      a_timer_mirror: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        unit_cfg_in[g].mode == CACT_MODE_TIMER |=> val_reg == $past(unit_cfg_in[g].compare))
        else $error("compare value not held");
      a_timer_irq: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        unit_cfg_in[g].irq_en ##0 s_count_hits_compare |=> irq_reg)
        else $error("compare match missed");
      a_irq_no_cause: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (!irq_reg && !(unit_cfg_in[g].irq_en && (cap_event[g] || match_event[g]))) |=> !irq_reg)
        else $error("interrupt without cause");
      a_irq_clears: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (irq_reg && unit_irq_clear_in[g] && !(unit_cfg_in[g].irq_en && cap_event[g]) &&
          !(unit_cfg_in[g].irq_en && match_event[g])) |=> !irq_reg)
        else $error("interrupt did not clear");
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_seen_reg <= 1'b0;
    end else begin
      tick_seen_reg <= tick;
    end
  end

  a_gate_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !array_clock_control_reg.gate |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved while gated");
  a_count_step: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    tick |=> cnt_reg == 16'($past(cnt_reg) + 16'h0001))
    else $error("counter did not step");
  a_exp_zero_tick: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (array_clock_control_reg.gate && array_clock_control_reg.exponent == 4'h0) |-> tick)
    else $error("divide by one missed tick");
  a_div_two_spacing: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (tick && array_clock_control_reg.exponent == 4'h1 && $stable(array_clock_control_reg))
    |=> !tick)
    else $error("divide by two ticked twice");
  a_reset_value: assert property (@(posedge clock_in)
    !rst_n_in |-> array_clock_control_reg == CACT_CLK_CTRL_RESET)
    else $error("clock control reset wrong");
  a_read_back: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (sfr_addr_in == CACT_CLK_CTRL_ADDR) |-> sfr_rdata_out[4:0] == array_clock_control_reg[4:0])
    else $error("clock control read wrong");

  a_write_lands: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (sfr_wr_in && sfr_addr_in == CACT_CLK_CTRL_ADDR) |=>
    (array_clock_control_reg.gate == $past(sfr_wdata_in[CACT_GATE_BIT])) &&
    (array_clock_control_reg.exponent == $past(sfr_wdata_in[CACT_EXP_MSB:0])) &&
    (array_clock_control_reg.rsvd == '0))
    else $error("clock control write lost");
  a_other_ignored: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (sfr_wr_in && sfr_addr_in != CACT_CLK_CTRL_ADDR) |=> $stable(array_clock_control_reg))
    else $error("foreign write changed clock control");
  a_gated_no_tick: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !array_clock_control_reg.gate |-> !tick)
    else $error("tick while gated");
  a_read_other: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (sfr_addr_in != CACT_CLK_CTRL_ADDR) |-> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule : cact_top

// File: cact_pins.sv
// pin-side model driving the capture inputs
`timescale 1ns/10ps
module cact_pins (
  input wire logic [2:0] level_in,
  output logic [2:0] pin_out
);
  initial pin_out = 3'b000;
  // pins are asynchronous: move off the clock edge
  always @(level_in) pin_out <= #3 level_in;
endmodule : cact_pins

// File: cact_top_test.sv
// self-checking testbench for the counter array
`timescale 1ns/10ps
module cact_top_test;
  import cact_pkg::*;
  logic clock_in = 0, rst_n_in = 1, sfr_wr_in = 0, array_tick_clock_out;
  logic [7:0] sfr_addr_in = 8'hFC, sfr_wdata_in = 0, sfr_rdata_out;
  cact_unit_cfg_s [2:0] unit_cfg_in = '0;
  logic [2:0] pin_lvl = 0, unit_pin_in, unit_irq_clear_in = 0, unit_irq_out;
  logic [2:0][15:0] capture_compare_value_out;
  logic [15:0] counter_out, c0;
  int fails = 0, samples_checked = 0, n;
  always #5 clock_in = ~clock_in;
  cact_top #(.UNITS(3)) uut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rdata_out(sfr_rdata_out), .unit_cfg_in(unit_cfg_in), .unit_pin_in(unit_pin_in),
    .unit_irq_clear_in(unit_irq_clear_in), .capture_compare_value_out(capture_compare_value_out),
    .unit_irq_out(unit_irq_out), .counter_out(counter_out),
    .array_tick_clock_out(array_tick_clock_out));
  cact_pins pins (.level_in(pin_lvl), .pin_out(unit_pin_in));
  task complete_run;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task cyc(input int k);
    repeat (k) @(negedge clock_in);
  endtask : cyc
  task wr(input logic [7:0] d);
    cyc(1);
    sfr_wdata_in = d;
    sfr_wr_in = 1;
    cyc(1);
    sfr_wr_in = 0;
  endtask : wr
  task wait_irq(input logic [2:0] m);
    n = 0;
    while ((unit_irq_out & m) !== m && n < 300) begin
      cyc(1);
      n++;
    end
    if (n == 300) begin
      fails++;
      complete_run();
    end
  endtask : wait_irq
  task clear_irq;
    unit_irq_clear_in = 3'b111;
    cyc(1);
    unit_irq_clear_in = 0;
    cyc(1);
  endtask : clear_irq
  task check_reg;
    cmp(sfr_rdata_out, CACT_CLK_CTRL_RESET);
    sfr_addr_in = CACT_CLK_CTRL_ADDR + 8'h01;
    cyc(1);
    cmp(sfr_rdata_out, 16'h0000);
    wr(8'h00);
    sfr_addr_in = CACT_CLK_CTRL_ADDR;
    cyc(1);
    cmp(sfr_rdata_out, CACT_CLK_CTRL_RESET);
    wr(8'hFF);
    cmp(sfr_rdata_out, 16'h001F);
    wr(CACT_CLK_CTRL_RESET);
  endtask : check_reg
  task check_gate;
    c0 = counter_out;
    cyc(10);
    cmp(counter_out, c0 + 16'd10);
    wr(8'h00);
    c0 = counter_out;
    cyc(10);
    cmp(counter_out, c0);
  endtask : check_gate
  task check_div;
    // skip a few cycles: an exponent change may give one short period
    for (int e = 0; e < 5; e++) begin
      wr(8'h10 | 8'(e));
      cyc(40);
      n = 0;
      repeat (64) begin
        cyc(1);
        n += int'(array_tick_clock_out);
      end
      cmp(16'(n), 16'(64 >> e));
    end
    wr(8'h10);
  endtask : check_div
  task check_capture;
    // no unit is ever put in pwm mode, so mixed modes stay legal
    for (int i = 0; i < 3; i++) begin
      unit_cfg_in[i].mode = CACT_MODE_CAPTURE;
      unit_cfg_in[i].edge_sel = cact_edge_e'(i + 1);
      unit_cfg_in[i].irq_en = 1;
    end
    pin_lvl = 3'b111;
    wait_irq(3'b101);
    cmp(capture_compare_value_out[0], counter_out - 16'd1);
    cyc(4);
    cmp(unit_irq_out, 3'b101);
    clear_irq();
    c0 = capture_compare_value_out[0];
    pin_lvl = 0;
    wait_irq(3'b110);
    cmp(capture_compare_value_out[1], counter_out - 16'h0001);
    cmp(capture_compare_value_out[0], c0);
    cyc(4);
    cmp(unit_irq_out, 3'b110);
    clear_irq();
    unit_cfg_in[2].irq_en = 0;
    pin_lvl = 3'b100;
    cyc(8);
    cmp(unit_irq_out, 0);
  endtask : check_capture
  task check_timer;
    unit_cfg_in = '0;
    unit_cfg_in[1].mode = CACT_MODE_TIMER;
    unit_cfg_in[1].irq_en = 1;
    unit_cfg_in[0].mode = CACT_MODE_TIMER;
    c0 = counter_out + 16'h0028;
    unit_cfg_in[1].compare = c0;
    unit_cfg_in[0].compare = c0;
    cyc(2);
    cmp(capture_compare_value_out[1], c0);
    cmp(capture_compare_value_out[0], c0);
    wait_irq(3'b010);
    cmp(counter_out, c0 + 16'h0001);
    cmp(unit_irq_out, 3'b010);
  endtask : check_timer
  task check_reset;
    unit_cfg_in = '0;
    rst_n_in = 0;
    cyc(2);
    cmp(counter_out, CACT_CNT_RESET);
    cmp(unit_irq_out, 16'h0000);
    cmp(capture_compare_value_out[1], CACT_CNT_RESET);
    cmp(sfr_rdata_out, CACT_CLK_CTRL_RESET);
    rst_n_in = 1;
    cyc(2);
    cmp(counter_out, 16'h0002);
  endtask : check_reset
  initial begin
    #1 rst_n_in = 0;
    cyc(8);
    rst_n_in = 1;
    cyc(1);
    check_reg();
    check_gate();
    check_div();
    check_capture();
    check_timer();
    check_reset();
    complete_run();
  end
endmodule : cact_top_test
